//--- src/clk_div_pkg.sv
// shared constants and types for the sample clock divider and retimer
package clk_div_pkg;
  // register indexes on the configuration port
  localparam logic [9:0] ADDR_SYNC_CTRL = 10'h100; // clock_sync_control
  localparam logic [9:0] ADDR_DUTY_CTRL = 10'h009; // duty_retimer enable
  localparam logic [9:0] ADDR_DIV_CTRL = 10'h00b; // divide ratio minus one
  // field positions
  localparam int SYNC_EN_BIT = 1; // realign on alignment pulses
  localparam int SYNC_FIRST_BIT = 2; // only first pulse after a write
  localparam int DUTY_EN_BIT = 0; // duty_retimer enable
  localparam int DIV_LSB = 0; // ratio field low bit
  localparam int DIV_MSB = 2; // ratio field high bit
  // reset values
  localparam logic [7:0] SYNC_CTRL_RST = 8'h00;
  localparam logic [7:0] DUTY_CTRL_RST = 8'h01;
  localparam logic [7:0] DIV_CTRL_RST = 8'h00;
  localparam logic [7:0] RD_NONE = 8'h00; // unmapped index reads zero
  // timing: relock interval after a clock rate change
  localparam int CLK_PERIOD_PS = 25000;
  localparam int RELOCK_MIN_PS = 1500000;
  localparam int RELOCK_MAX_PS = 5000000;
  localparam int RELOCK_CYC_I = (RELOCK_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [7:0] RELOCK_CYC = 8'(RELOCK_CYC_I);
  localparam logic [2:0] DIV_ONE = 3'h0; // encoded ratio of one
  localparam logic [2:0] CNT_INIT = 3'h0; // divider initial state
  // one register write or read request
  typedef struct packed {
    logic wr; // write strobe, one cycle
    logic [9:0] addr; // register index
    logic [7:0] data; // write data
  } reg_req_t;
  // retimer state seen outside
  typedef struct packed {
    logic on; // retimer shaping the falling edge
    logic locked; // loop locked
    logic armed; // first-pulse realign armed
  } clk_status_t;
endpackage

//--- src/sync_pulse_catch.sv
// three-stage synchroniser and rising edge detect for the alignment pulse
`timescale 1ns/100ps
`default_nettype none
module sync_pulse_catch (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic pin_in,
  output logic pulse
);
  logic s1, s2, s3; // synchroniser chain, s1 feeds s2 only
  logic level; // filtered level
  // chain and agreement filter
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
      pulse <= 1'b0;
    end else begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level <= s3;
      end
      pulse <= (s2 == s3) && s3 && !level; // one cycle per pulse
    end
  end
endmodule
`default_nettype wire

//--- src/sample_clock_divider_sync.sv
// sample clock divider with alignment and duty_retimer control
// Overview of operation
// - divide sample clock by one to eight
// - ratio above one forces retimer on
// - bits one, two select every/first pulse
// - accepted pulse returns divider to initial state
// - retimer sets half-period high, rising untouched
// - retimer off below twenty megahertz
// - relock interval after rate change, bypassed
// - sample on rising edge of divided clock
`timescale 1ns/100ps
`default_nettype none
module sample_clock_divider_sync
  import clk_div_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic sync_pin,
  input wire logic rate_low,
  input wire logic rate_change,
  output logic sample_clk,
  output logic sample_strobe,
  output clk_status_t status
);
  logic [7:0] sync_ctrl; // clock_sync_control
  logic [7:0] duty_ctrl; // retimer enable register
  logic [7:0] div_ctrl; // ratio register
  logic [2:0] div_cnt; // divider phase
  logic [7:0] lock_cnt; // relock timer
  logic armed; // first-pulse realign armed
  logic sync_pulse; // filtered pulse edge
  logic locked_q; // loop locked flag
  logic retimer_on_q; // retimer shaping edges

  // half of the ratio, at least one cycle
  // odd ratios above one round the high time down, so the low phase is one cycle longer
  function automatic logic [2:0] half_len(input logic [2:0] r_m1);
    logic [3:0] r;
    r = {1'b0, r_m1} + 4'h1;
    half_len = (r < 4'h2) ? 3'h1 : r[3:1];
  endfunction

  // alignment pulse catcher
  // the pin is asynchronous to mclk, so it passes three flops before use
  sync_pulse_catch u_catch (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin_in(sync_pin),
    .pulse(sync_pulse)
  );

  // write decode
  // writes land on the edge that samples the strobe; no wait states
  wire wr_sync = reg_req.wr && (reg_req.addr == ADDR_SYNC_CTRL);
  wire wr_duty = reg_req.wr && (reg_req.addr == ADDR_DUTY_CTRL);
  wire wr_div = reg_req.wr && (reg_req.addr == ADDR_DIV_CTRL);
  // control fields
  wire sync_en = sync_ctrl[SYNC_EN_BIT];
  wire first_only = sync_ctrl[SYNC_FIRST_BIT];
  wire [2:0] ratio_m1 = div_ctrl[DIV_MSB:DIV_LSB];
  // pulse acceptance, every pulse or first after write
  // the request passes only while sync is enabled and, in first-pulse mode,
  // only while armed by a write
  wire sync_accept = sync_en && sync_pulse && (!first_only || armed);
  // end of a divide period
  wire wrap = div_cnt >= ratio_m1;
  wire [2:0] next_cnt = (sync_accept || wrap) ? CNT_INIT : div_cnt + 3'h1;
  // retimer request: enable bit or ratio above one
  wire retimer_req = duty_ctrl[DUTY_EN_BIT] || (ratio_m1 != DIV_ONE);
  // conditions that throw the loop out of lock
  // a ratio write counts as a rate change: the divided clock jumps at once
  // a low clock rate keeps the loop in bypass for as long as it lasts
  wire lock_lost = rate_change || rate_low || !retimer_req || wr_div;
  wire next_locked = !lock_lost && (lock_cnt >= RELOCK_CYC - 8'h1);
  wire next_on = retimer_req && next_locked; // bypass until locked
  // high time: half period if retimed, else one input cycle
  wire [2:0] high_len = next_on ? half_len(ratio_m1) : 3'h1;
  // the clock only rises with the sampling strobe; when the retimer comes on or
  // goes off mid-period the high phase may shorten or lengthen but never starts
  // away from the rising edge, so the sampling instant is left alone
  wire next_sclk = (next_cnt == CNT_INIT) || (sample_clk && (next_cnt < high_len));
  // read mux
  // unmapped indexes read as zero
  wire [7:0] next_rdata = (reg_req.addr == ADDR_SYNC_CTRL) ? sync_ctrl :
                          (reg_req.addr == ADDR_DUTY_CTRL) ? duty_ctrl :
                          (reg_req.addr == ADDR_DIV_CTRL) ? div_ctrl : RD_NONE;

  // configuration registers
  // reads are registered, so read data follows the index by one cycle;
  // writes to unmapped indexes fall through and change nothing
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sync_ctrl <= SYNC_CTRL_RST;
      duty_ctrl <= DUTY_CTRL_RST;
      div_ctrl <= DIV_CTRL_RST;
      reg_rdata <= RD_NONE;
    end else begin
      if (wr_sync) begin
        sync_ctrl <= reg_req.data;
      end
      if (wr_duty) begin
        duty_ctrl <= reg_req.data;
      end
      if (wr_div) begin
        div_ctrl <= reg_req.data;
      end
      reg_rdata <= next_rdata;
    end
  end

  // first-pulse arming, write wins over the clearing pulse
  // a write in the same cycle as an accepted pulse leaves the divider re-armed
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      armed <= 1'b0;
    end else if (wr_sync) begin
      armed <= 1'b1;
    end else if (sync_accept && first_only) begin
      armed <= 1'b0;
    end
  end

  // divider and sampling edge
  // a realignment restarts the count at once, so a period in progress is cut
  // short and the next sampling edge follows in the very next cycle
  // with a ratio of one the clock stays high and every edge samples
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      div_cnt <= CNT_INIT;
      sample_strobe <= 1'b0;
      sample_clk <= 1'b0;
    end else begin
      div_cnt <= next_cnt;
      sample_strobe <= sync_accept || wrap; // rising edge marker
      sample_clk <= next_sclk; // falling edge placement
    end
  end

  // relock timer
  // the count restarts on every loss condition and stops once the loop is
  // locked, so lock comes exactly one relock interval after the last loss
  // the relock interval is rounded up to whole input clock cycles
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lock_cnt <= 8'h00;
      locked_q <= 1'b0;
      retimer_on_q <= 1'b0;
    end else begin
      if (lock_lost) begin
        lock_cnt <= 8'h00;
      end else if (!next_locked) begin
        lock_cnt <= lock_cnt + 8'h1;
      end
      locked_q <= next_locked;
      retimer_on_q <= next_on;
    end
  end

  // status outputs
  // status mirrors the internal flags one cycle behind their next values,
  // so it leaves the top module straight from flip-flops
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      status <= '0;
    end else begin
      status.on <= next_on;
      status.locked <= next_locked;
      status.armed <= wr_sync ? 1'b1 : ((sync_accept && first_only) ? 1'b0 : armed);
    end
  end

  // checks
  // every property is sampled on the input clock; reset disables them all
  // the exact high-time lengths are counted by the bench at each falling edge
  // lock timing is tied to the relock counter, not to wall-clock time
  AST_DIV_WRAP: assert property (@(posedge mclk) disable iff (sys_rst)
    (wrap && !sync_accept) |=> (div_cnt == CNT_INIT) && sample_strobe)
    else $error("divider did not wrap at ratio");
  AST_FORCE_RETIMER: assert property (@(posedge mclk) disable iff (sys_rst)
    ((ratio_m1 != DIV_ONE) && !rate_change && !rate_low && !wr_div) |=> (lock_cnt != 8'h00) || status.locked)
    else $error("ratio above one did not keep the retimer loop running");
  AST_FIRST_ONLY: assert property (@(posedge mclk) disable iff (sys_rst)
    (sync_pulse && first_only && !armed) |-> !sync_accept)
    else $error("pulse accepted while disarmed");
  AST_REALIGN: assert property (@(posedge mclk) disable iff (sys_rst)
    sync_accept |=> (div_cnt == CNT_INIT) && sample_strobe)
    else $error("divider not returned to initial state");
  AST_RISE_AT_STROBE: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(sample_clk) |-> sample_strobe)
    else $error("sample clock rose away from sampling edge");
  AST_LOW_RATE: assert property (@(posedge mclk) disable iff (sys_rst)
    rate_low |=> !retimer_on_q && !status.on)
    else $error("retimer active below low rate limit");
  AST_RELOCK_HOLD: assert property (@(posedge mclk) disable iff (sys_rst)
    rate_change |=> !locked_q [*8])
    else $error("retimer relocked too soon");
  AST_LOCK_TIME: assert property (@(posedge mclk) disable iff (sys_rst)
    $rose(locked_q) |-> $past(lock_cnt) == RELOCK_CYC - 8'h1)
    else $error("lock not after relock interval");
  AST_STROBE_PERIOD: assert property (@(posedge mclk) disable iff (sys_rst)
    (sample_strobe && !sync_accept && !wr_div && div_cnt == CNT_INIT && ratio_m1 == 3'h1)
    |=> !sample_strobe ##1 sample_strobe)
    else $error("strobe spacing wrong for ratio two");
  AST_DISARM: assert property (@(posedge mclk) disable iff (sys_rst)
    (sync_accept && first_only && !wr_sync) |=> !armed)
    else $error("first pulse did not disarm");
  AST_ARM_ON_WRITE: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_sync |=> armed && status.armed)
    else $error("write to sync control did not arm");
  // main scenarios reached by the tests
  COV_REALIGN: cover property (@(posedge mclk) disable iff (sys_rst) sync_accept);
  COV_LOCK: cover property (@(posedge mclk) disable iff (sys_rst) $rose(locked_q));
  COV_DIV8: cover property (@(posedge mclk) disable iff (sys_rst) sample_strobe && ratio_m1 == 3'h7);
  COV_DISARM: cover property (@(posedge mclk) disable iff (sys_rst) sync_accept && first_only);
  COV_LOW_RATE: cover property (@(posedge mclk) disable iff (sys_rst) rate_low && status.on);
endmodule
`default_nettype wire

//--- src/_end.sv
// intentionally empty compilation unit
`default_nettype wire

//--- verif/sync_source.sv
// far side model: alignment pulse source and clock rate change notice
`timescale 1ns/100ps
`default_nettype none
module sync_source (
  input wire logic mclk,
  input wire logic fire_sync,
  input wire logic fire_rate,
  output logic sync_pin,
  output logic rate_change
);
  int hold = 0; // cycles of pin high still owed
  logic fs; // sampled sync request
  logic fr; // sampled rate request
  initial sync_pin = 1'b0;
  initial rate_change = 1'b0;
  // requests taken on the edge, pins moved just after it
  always @(posedge mclk) begin
    fs = fire_sync;
    fr = fire_rate;
    #1;
    hold = fs ? 3 : (hold > 0 ? hold - 1 : 0);
    sync_pin = (hold > 0);
    rate_change = fr; // relock wait is left to the bench
  end
endmodule
`default_nettype wire

//--- verif/sample_clock_divider_sync_tb.sv
// self-checking bench for the sample clock divider
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module sample_clock_divider_sync_tb;
  import clk_div_pkg::*;
  logic mclk = 0, sys_rst = 1, rate_low = 0, fire_sync = 0, fire_rate = 0;
  reg_req_t reg_req = '0;
  logic [7:0] reg_rdata, d;
  logic sync_pin, rate_change, sample_clk, sample_strobe;
  clk_status_t status;
  int miscompares = 0, checked = 0, cyc = 0, r = 1, since = 0, hi = 0, st = 0;
  bit aligned = 0, sync_en = 0, first = 0, armed = 0, pin_q = 0, clk_q = 0, on_q = 0;
  int acc_q[$]; // cycles at which accepted pulses land
  always #12.5 mclk = ~mclk;
  sample_clock_divider_sync dut (.mclk(mclk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .sync_pin(sync_pin), .rate_low(rate_low), .rate_change(rate_change), .sample_clk(sample_clk),
    .sample_strobe(sample_strobe), .status(status));
  sync_source u_src (.mclk(mclk), .fire_sync(fire_sync), .fire_rate(fire_rate), .sync_pin(sync_pin),
    .rate_change(rate_change));
  // reference model of divider phase, checked every cycle once aligned
  always @(posedge mclk) begin
    #2;
    cyc++;
    if (sync_pin && !pin_q && sync_en && (!first || armed)) begin
      acc_q.push_back(cyc + 5);
      armed = 0;
    end
    pin_q = sync_pin;
    if (acc_q.size() > 0 && acc_q[0] == cyc) begin
      void'(acc_q.pop_front());
      aligned = 1;
      hi = 0; // a realignment starts a new high phase
      since = 0;
      `CHK("sync strobe", 1'b1, sample_strobe)
    end else if (aligned) begin
      since++;
      `CHK("strobe", since == r, sample_strobe)
      if (since == r) since = 0;
    end
    st = (status.on === on_q) ? st + 1 : 0;
    on_q = status.on;
    hi = sample_clk ? hi + 1 : hi;
    if (clk_q && !sample_clk) begin
      if (aligned && r > 1 && st > 10) `CHK("high time", on_q ? r / 2 : 1, hi)
      hi = 0;
    end
    clk_q = sample_clk;
  end
  // one register write, model registers follow
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge mclk);
    #1;
    reg_req = '{wr: 1'b1, addr: a, data: v};
    if (a == ADDR_DIV_CTRL) begin
      aligned = 0;
      r = v[DIV_MSB:DIV_LSB] + 1;
    end
    if (a == ADDR_SYNC_CTRL) begin
      sync_en = v[SYNC_EN_BIT];
      first = v[SYNC_FIRST_BIT];
      armed = 1;
    end
    @(posedge mclk);
    #1;
    reg_req.wr = 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge mclk);
    #1;
    reg_req.addr = a;
    @(posedge mclk);
    #2;
    `CHK("rdata", e, reg_rdata)
  endtask
  // one-cycle request to the far side model
  task automatic fire(input bit s);
    @(posedge mclk);
    #1;
    if (s) fire_sync = 1;
    else fire_rate = 1;
    @(posedge mclk);
    #1;
    fire_sync = 0;
    fire_rate = 0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic end_sim;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog well beyond the planned run
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    end_sim();
  end
  initial begin
    void'($urandom(58));
    repeat (16) @(posedge mclk);
    #1 sys_rst = 0;
    rd(ADDR_SYNC_CTRL, SYNC_CTRL_RST);
    rd(ADDR_DUTY_CTRL, DUTY_CTRL_RST);
    rd(ADDR_DIV_CTRL, DIV_CTRL_RST);
    rd(10'h3ff, RD_NONE);
    $display("test reset values done");
    wr(ADDR_DUTY_CTRL, 8'h00);
    // every ratio, realigned twice mid-phase
    for (int k = 0; k < 8; k++) begin
      d = {5'($urandom), 3'(k)};
      wr(ADDR_DIV_CTRL, d);
      rd(ADDR_DIV_CTRL, d);
      wr(ADDR_SYNC_CTRL, 8'h02);
      fire(1);
      idle(10 + $urandom % 9);
      fire(1);
      idle(70);
      `CHK("retimer forced", k > 0, status.on)
    end
    $display("test divider ratios done");
    @(posedge mclk);
    #1 rate_low = 1;
    idle(5);
    `CHK("low rate off", 1'b0, status.on)
    idle(40);
    @(posedge mclk);
    #1 rate_low = 0;
    idle(30);
    `CHK("unlocked", 1'b0, status.locked)
    idle(40);
    `CHK("relocked", 1'b1, status.locked)
    fire(0);
    idle(30);
    `CHK("change unlocks", 1'b0, status.locked)
    idle(40);
    `CHK("change relocks", 1'b1, status.on)
    $display("test retimer lock done");
    wr(ADDR_SYNC_CTRL, 8'h06);
    idle(1);
    `CHK("armed", 1'b1, status.armed)
    fire(1);
    idle(20);
    `CHK("disarmed", 1'b0, status.armed)
    fire(1);
    idle(20 + $urandom % 8);
    wr(ADDR_SYNC_CTRL, 8'h00);
    fire(1);
    idle(20);
    $display("test sync modes done");
    end_sim();
  end
endmodule
`default_nettype wire
